// ==== pkg/l1rt_params.svh ====
/*
 * Register map, field positions, reset values and timing figures of the
 * L1 entry rejection timer.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef L1RT_PARAMS_SVH
`define L1RT_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses on APB)
`define L1RT_ADDR_W        12
`define L1RT_CTRL_ADDR     12'h0710
`define L1RT_STAT_ADDR     12'h0714

// ==========================================================================
// Control word layout and reset values
`define L1RT_GAP_W         14
`define L1RT_GAP_LSB       0
`define L1RT_GAP_MSB       13
`define L1RT_TSEL_BIT      16
`define L1RT_GAP_RST       14'h0947
`define L1RT_TSEL_RST      1'h1

// ==========================================================================
// Status word layout
`define L1RT_ST_HOLD_BIT   0
`define L1RT_ST_REQ_BIT    1
`define L1RT_ST_EXP_BIT    2
`define L1RT_ST_RST_LSB    8
`define L1RT_ST_RST_MSB    15
`define L1RT_ST_DIS_LSB    16
`define L1RT_ST_DIS_MSB    31

// ==========================================================================
// Timing: one interval count is one 4 ns tick; pclk period is 25 ns
`define L1RT_UNIT_NS       4
`define L1RT_PCLK_NS       25
`define L1RT_ACC_W         17

`endif

// ==== pkg/l1rt_pkg.sv ====
/*
 * Types shared by the L1 entry rejection timer design files.
 * Assumes the params header is on the include path.
 */
`include "l1rt_params.svh"

package l1rt_pkg;

  // ========================================================================
  // Port state, one-hot
  typedef enum logic [2:0] {
    L1RT_ST_IDLE = 3'b001,
    L1RT_ST_REQ  = 3'b010,
    L1RT_ST_HOLD = 3'b100
  } l1rt_state_t;

  // ========================================================================
  // Software control fields
  typedef struct packed {
    logic                    tsel;
    logic [`L1RT_GAP_W-1:0]  gap;
  } l1rt_ctrl_t;

  // ========================================================================
  // One-cycle events from the link layer, same clock
  typedef struct packed {
    logic req_rx;    // Active-state L1 request DLLP received
    logic nak_sent;  // Port has issued the L1 Nak
    logic ack_sent;  // Port has accepted the request
  } l1rt_link_ev_t;

endpackage : l1rt_pkg

// ==== core/l1rt_gap_timer.sv ====
/*
 * Interval timer: measures elapsed time in ns at the pclk rate and
 * flags when it has reached the programmed count of 4 ns ticks.
 * Assumes pclk at 25 ns and the package and params header in scope.
 */
`include "l1rt_params.svh"

module l1rt_gap_timer
  import l1rt_pkg::*;
#(
  parameter int GAP_W = `L1RT_GAP_W,
  parameter int ACC_W = `L1RT_ACC_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  input  wire logic              restart,
  input  wire logic [GAP_W-1:0]  gap,
  output logic                   expired,
  output logic [ACC_W-1:0]       elapsed
);

  logic [ACC_W-1:0] elapsed_ff;
  logic [ACC_W-1:0] nxt_elapsed;
  logic [ACC_W-1:0] target_ns;

  // ========================================================================
  // Comparison
  // Gap is read live, so a rewrite during a hold moves the end point.
  assign target_ns = ACC_W'(gap) * ACC_W'(`L1RT_UNIT_NS);
  assign expired   = run && (elapsed_ff >= target_ns);
  assign elapsed   = elapsed_ff;

  // ========================================================================
  // Counter; stops once expired so it cannot wrap
  always_comb begin
    nxt_elapsed = elapsed_ff;
    if (restart || !run) begin
      nxt_elapsed = '0;
    end else if (!expired) begin
      nxt_elapsed = elapsed_ff + ACC_W'(`L1RT_PCLK_NS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_ff <= '0;
    end else begin
      elapsed_ff <= nxt_elapsed;
    end
  end

  // ========================================================================
  // Checks
  restart_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> elapsed_ff == '0)
    else $error("timer did not clear on restart");

  tick_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && !restart && !expired
      |=> elapsed_ff == $past(elapsed_ff) + ACC_W'(`L1RT_PCLK_NS))
    else $error("timer did not advance by one period");

endmodule // l1rt_gap_timer

// ==== core/l1rt_top.sv ====
/*
 * L1 entry rejection timer for one switch port, with its APB registers.
 * Assumes link events arrive as one-cycle pulses on pclk from the
 * port's link layer, and an APB master on the same pclk.
 */
`include "l1rt_params.svh"

module l1rt_top
  import l1rt_pkg::*;
#(
  parameter int ADDR_W = `L1RT_ADDR_W,
  parameter int CNT_W  = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire l1rt_link_ev_t       link_ev,
  output logic                     req_detect,
  output logic                     req_discard,
  output logic                     timer_running
);

  l1rt_ctrl_t            ctrl_ff;
  l1rt_state_t           state_ff;
  l1rt_state_t           nxt_state;
  logic                  req_detect_ff;
  logic                  req_discard_ff;
  logic                  nxt_detect;
  logic                  nxt_discard;
  logic                  tmr_restart;
  logic                  tmr_expired;
  logic [`L1RT_ACC_W-1:0] tmr_elapsed;
  logic [CNT_W-1:0]      discard_cnt_ff;
  logic [7:0]            restart_cnt_ff;
  logic [31:0]           prdata_ff;
  logic                  pslverr_ff;
  logic                  setup_ph;
  logic                  wr_ctrl;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  in_hold;
  logic                  early_req;
  logic [31:0]           ctrl_word;
  logic [31:0]           stat_word;
  logic [15:0]           hold_cyc_ff;

  // ========================================================================
  // APB decode; zero wait states
  assign setup_ph = psel && !penable;
  assign hit_ctrl = (paddr == ADDR_W'(`L1RT_CTRL_ADDR));
  assign hit_stat = (paddr == ADDR_W'(`L1RT_STAT_ADDR));
  assign wr_ctrl  = psel && penable && pwrite && hit_ctrl;
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff && psel && penable;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`L1RT_GAP_MSB:`L1RT_GAP_LSB] = ctrl_ff.gap;
    ctrl_word[`L1RT_TSEL_BIT] = ctrl_ff.tsel;
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`L1RT_ST_HOLD_BIT] = (state_ff == L1RT_ST_HOLD);
    stat_word[`L1RT_ST_REQ_BIT]  = (state_ff == L1RT_ST_REQ);
    stat_word[`L1RT_ST_EXP_BIT]  = tmr_expired;
    stat_word[`L1RT_ST_RST_MSB:`L1RT_ST_RST_LSB] = restart_cnt_ff;
    stat_word[`L1RT_ST_DIS_MSB:`L1RT_ST_DIS_LSB] = 16'(discard_cnt_ff);
  end

  // Read data is captured in the setup phase, so status is one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      pslverr_ff <= !(hit_ctrl || hit_stat);
      if (pwrite || !(hit_ctrl || hit_stat)) begin
        prdata_ff <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_ff <= ctrl_word;
      end else begin
        prdata_ff <= stat_word;
      end
    end
  end

  // ========================================================================
  // Control register; byte lanes honoured, reserved bits not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff.gap  <= `L1RT_GAP_RST;
      ctrl_ff.tsel <= `L1RT_TSEL_RST;
    end else if (wr_ctrl) begin
      if (pstrb[0]) begin
        ctrl_ff.gap[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        ctrl_ff.gap[`L1RT_GAP_MSB:8] <= pwdata[`L1RT_GAP_MSB:8];
      end
      if (pstrb[2]) begin
        ctrl_ff.tsel <= pwdata[`L1RT_TSEL_BIT];
      end
    end
  end

  // ========================================================================
  // Request tracking
  assign in_hold     = (state_ff == L1RT_ST_HOLD);
  assign early_req   = in_hold && !tmr_expired && link_ev.req_rx;
  // Entering hold needs no restart: the timer sits at zero outside hold
  assign tmr_restart = early_req && !ctrl_ff.tsel;

  always_comb begin
    nxt_state   = state_ff;
    nxt_detect  = 1'b0;
    nxt_discard = 1'b0;
    unique case (state_ff)
      L1RT_ST_IDLE: begin
        if (link_ev.req_rx) begin
          nxt_state  = L1RT_ST_REQ;
          nxt_detect = 1'b1;
        end
      end
      L1RT_ST_REQ: begin
        // Further DLLPs belong to the same request until it is answered
        if (link_ev.nak_sent) begin
          nxt_state = L1RT_ST_HOLD;
        end else if (link_ev.ack_sent) begin
          nxt_state = L1RT_ST_IDLE;
        end
      end
      L1RT_ST_HOLD: begin
        if (tmr_expired) begin
          // A DLLP in the expiry cycle already counts as new
          nxt_state  = link_ev.req_rx ? L1RT_ST_REQ : L1RT_ST_IDLE;
          nxt_detect = link_ev.req_rx;
        end else if (early_req && ctrl_ff.tsel) begin
          nxt_discard = 1'b1;
        end
      end
      default: begin
        nxt_state = L1RT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= L1RT_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_detect_ff  <= 1'b0;
      req_discard_ff <= 1'b0;
    end else begin
      req_detect_ff  <= nxt_detect;
      req_discard_ff <= nxt_discard;
    end
  end

  assign req_detect    = req_detect_ff;
  assign req_discard   = req_discard_ff;
  assign timer_running = in_hold;

  // ========================================================================
  // Saturating event counters for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_cnt_ff <= '0;
    end else if (nxt_discard && (discard_cnt_ff != '1)) begin
      discard_cnt_ff <= discard_cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_cnt_ff <= 8'h00;
    end else if (tmr_restart && (restart_cnt_ff != 8'hff)) begin
      restart_cnt_ff <= restart_cnt_ff + 8'h01;
    end
  end

  // ========================================================================
  // Interval timer
  l1rt_gap_timer #(
    .GAP_W (`L1RT_GAP_W),
    .ACC_W (`L1RT_ACC_W)
  ) u_gap_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (in_hold),
    .restart (tmr_restart),
    .gap     (ctrl_ff.gap),
    .expired (tmr_expired),
    .elapsed (tmr_elapsed)
  );

  // ========================================================================
  // Checks; hold_cyc_ff counts hold cycles independently of the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cyc_ff <= 16'h0000;
    end else if (!in_hold || tmr_restart) begin
      hold_cyc_ff <= 16'h0000;
    end else if (hold_cyc_ff != 16'hffff) begin
      hold_cyc_ff <= hold_cyc_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gap_write_a: assert property (
    wr_ctrl && pstrb[0] && pstrb[1]
      |=> ctrl_ff.gap == $past(pwdata[`L1RT_GAP_MSB:`L1RT_GAP_LSB]))
    else $error("interval write not stored");

  rsvd_read_a: assert property (
    psel && penable && !pwrite && hit_ctrl
      |-> prdata[15:14] == 2'b00 && prdata[31:17] == 15'h0000)
    else $error("reserved control bits read nonzero");

  hold_min_a: assert property (
    in_hold && nxt_state != L1RT_ST_HOLD
      |-> 32'(hold_cyc_ff) * 32'(`L1RT_PCLK_NS)
          >= 32'(ctrl_ff.gap) * 32'(`L1RT_UNIT_NS))
    else $error("hold ended before the interval");

  nak_start_a: assert property (
    state_ff == L1RT_ST_REQ && link_ev.nak_sent
      |=> in_hold && tmr_elapsed == '0)
    else $error("nak did not start the timer");

  seq_join_a: assert property (
    state_ff == L1RT_ST_REQ && link_ev.req_rx
      |=> !req_detect_ff)
    else $error("repeat DLLP seen as a new request");

  ack_end_a: assert property (
    state_ff == L1RT_ST_REQ && link_ev.ack_sent && !link_ev.nak_sent
      |=> state_ff == L1RT_ST_IDLE)
    else $error("ack did not end the request");

  restart_mode_a: assert property (
    early_req && !ctrl_ff.tsel
      |=> in_hold && tmr_elapsed == '0 && !req_detect_ff)
    else $error("early request did not restart timer");

  ignore_mode_a: assert property (
    early_req && ctrl_ff.tsel && tmr_elapsed != '0
      |=> req_discard_ff && !req_detect_ff && tmr_elapsed != '0)
    else $error("early request disturbed the timer");

  new_req_a: assert property (
    (state_ff == L1RT_ST_IDLE || (in_hold && tmr_expired)) && link_ev.req_rx
      |=> req_detect_ff ##1 !req_detect_ff)
    else $error("request after expiry not detected");

  hold_wait_a: assert property (
    in_hold && !tmr_expired |=> in_hold)
    else $error("hold ended before expiry");

  hold_quiet_a: assert property (
    in_hold && !tmr_expired |=> !req_detect_ff)
    else $error("request detected during the interval");

  discard_cause_a: assert property (
    req_discard_ff |-> $past(in_hold && ctrl_ff.tsel && link_ev.req_rx))
    else $error("discard pulse without an early request");

  tsel_write_a: assert property (
    wr_ctrl && pstrb[2]
      |=> ctrl_ff.tsel == $past(pwdata[`L1RT_TSEL_BIT]))
    else $error("start select write not stored");

  idle_quiet_a: assert property (
    state_ff == L1RT_ST_IDLE && !link_ev.req_rx
      |=> state_ff == L1RT_ST_IDLE && !req_detect_ff)
    else $error("idle left without a request");

endmodule // l1rt_top

// ==== testbench/l1rt_link_partner.sv ====
/*
 * Link partner model: sends bursts of L1 request DLLP events, then the
 * port's verdict (nak or ack) as one-cycle pulses.
 * Assumes the same pclk as the design and the package in scope.
 */
module l1rt_link_partner
  import l1rt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [2:0]  n_req,
  input  wire logic [2:0]  space,
  input  wire logic [1:0]  verdict,
  output l1rt_link_ev_t    link_ev,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;

  int         left_ff;
  int         wait_ff;
  logic [1:0] vd_ff;

  // ==========================================================================
  // Burst engine; verdict 0 leaves the request open, as extra DLLPs do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ev <= '0;
      busy    <= 1'b0;
      left_ff <= 0;
      wait_ff <= 0;
      vd_ff   <= 2'h0;
    end else begin
      link_ev <= '0;
      if (start && !busy) begin
        busy    <= 1'b1;
        left_ff <= n_req;
        wait_ff <= 0;
        vd_ff   <= verdict;
      end else if (busy) begin
        if (wait_ff > 0) begin
          wait_ff <= wait_ff - 1;
        end else if (left_ff > 0) begin
          link_ev.req_rx <= 1'b1;
          left_ff        <= left_ff - 1;
          wait_ff        <= space;
        end else begin
          link_ev.nak_sent <= (vd_ff == 2'h1);
          link_ev.ack_sent <= (vd_ff == 2'h2);
          busy             <= 1'b0;
        end
      end
    end
  end
endmodule // l1rt_link_partner

// ==== testbench/l1_aspm_reject_timer_tb.sv ====
/*
 * Self-checking bench: APB register checks and random link rounds, with
 * a cycle model of the rejection timer compared every cycle.
 * Assumes the params header on the include path and the partner model.
 */
`include "l1rt_params.svh"

module l1_aspm_reject_timer_tb
  import l1rt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd_q, seed, v;
  logic [3:0]    pstrb;
  logic          err_q, req_detect, req_discard, timer_running;
  l1rt_link_ev_t link_ev;
  logic          p_start, p_busy;
  logic [2:0]    p_nreq, p_space;
  logic [1:0]    p_verdict;
  int            err_count, num_checks, m_st, m_cnt, m_gap, gap_v;
  int            m_nrst, m_ndis;
  logic          m_sel, e_det, e_dis;

  l1rt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_ev(link_ev), .req_detect(req_detect), .req_discard(req_discard),
    .timer_running(timer_running));

  l1rt_link_partner i_partner (.pclk(pclk), .presetn(presetn),
    .start(p_start), .n_req(p_nreq), .space(p_space),
    .verdict(p_verdict), .link_ev(link_ev), .busy(p_busy));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Reporting
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_ev(input logic got, input logic exp, input string n);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %b exp %b", $time, n, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ==========================================================================
  // APB master and link drivers
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      give_verdict();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, `L1RT_CTRL_ADDR, d, s);
    if (s[0]) m_gap[7:0] = d[7:0];
    if (s[1]) m_gap[13:8] = d[13:8];
    if (s[2]) m_sel = d[16];
  endtask

  task automatic reg_chk(input logic [11:0] a, input logic [31:0] e,
                         input logic e_err);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk_word(rd_q, e);
    chk_word({31'h0, err_q}, {31'h0, e_err});
  endtask

  task automatic burst(input logic [2:0] n, input logic [2:0] sp,
                       input logic [1:0] vd);
    int k;
    k = 0;
    @(posedge pclk);
    p_start   <= 1'b1;
    p_nreq    <= n;
    p_space   <= sp;
    p_verdict <= vd;
    @(posedge pclk);
    p_start <= 1'b0;
    do begin
      @(negedge pclk);
      k++;
    end while (p_busy !== 1'b0 && k < 200);
    if (k >= 200) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (timer_running !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      err_count++;
      give_verdict();
    end
  endtask

  // ==========================================================================
  // Cycle model; the hold ends at the first edge where 25 ns steps reach
  // the programmed count of 4 ns ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_st = 0;
      m_nrst = 0;
      m_ndis = 0;
      m_cnt = 0;
      e_det = 1'b0;
      e_dis = 1'b0;
    end else begin
      e_det = 1'b0;
      e_dis = 1'b0;
      case (m_st)
        0: if (link_ev.req_rx) begin
          e_det = 1'b1;
          m_st = 1;
        end
        1: if (link_ev.nak_sent) begin
          m_st = 2;
          m_cnt = 0;
        end else if (link_ev.ack_sent) begin
          m_st = 0;
        end
        default: if (m_cnt * `L1RT_PCLK_NS >= m_gap * `L1RT_UNIT_NS) begin
          e_det = link_ev.req_rx;
          m_st = link_ev.req_rx ? 1 : 0;
        end else if (link_ev.req_rx && !m_sel) begin
          m_cnt = 0;
          m_nrst++;
        end else begin
          e_dis = link_ev.req_rx & m_sel;
          m_ndis += e_dis;
          m_cnt++;
        end
      endcase
    end
  end

  always @(negedge pclk) begin
    if (presetn) begin
      chk_ev(req_detect, e_det, "detect");
      chk_ev(req_discard, e_dis, "discard");
      chk_ev(timer_running, m_st == 2, "running");
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {p_start, p_nreq, p_space, p_verdict} = '0;
    presetn = 1'b0;
    err_count = 0;
    num_checks = 0;
    seed = 32'h0000_0F60;
    m_gap = 14'h0947;
    m_sel = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    reg_chk(`L1RT_CTRL_ADDR, 32'h0001_0947, 1'b0);
    reg_wr(32'hFFFF_FFFF, 4'hF);
    reg_chk(`L1RT_CTRL_ADDR, 32'h0001_3FFF, 1'b0);
    reg_wr(32'h0000_0000, 4'b0100);
    reg_chk(`L1RT_CTRL_ADDR, 32'h0000_3FFF, 1'b0);
    reg_chk(12'h7F0, 32'h0000_0000, 1'b1);
    reg_chk(`L1RT_STAT_ADDR, 32'h0000_0000, 1'b0);
    $display("test registers done");
    // Random gaps keep the hold short while still hitting the expiry edge
    for (int r = 0; r < 40; r++) begin
      v = rnd();
      gap_v = (r == 0) ? 0 : v[9:4];
      reg_wr({15'h0, v[0], 2'b00, 8'h00, gap_v[5:0]}, 4'hF);
      burst(3'(1 + v[11:10]), {1'b0, v[13:12]},
            (v[16:15] == 2'h0) ? 2'h2 : 2'h1);
      burst(v[19:17], v[22:20], 2'h0);
      wait_idle();
      burst(3'h0, 3'h0, 2'h2);
    end
    // Restart count saturates at 255 in the status word
    v = {16'(m_ndis), ((m_nrst > 255) ? 8'hff : 8'(m_nrst)), 8'h00};
    reg_chk(`L1RT_STAT_ADDR, v, 1'b0);
    $display("test link rounds done");
    give_verdict();
  end
endmodule // l1_aspm_reject_timer_tb
